// file: hw/analog_comparator_control.sv
/*
 * Control and status logic of one analog comparator with an Avalon-MM
 * register slave, edge event flag, interrupt and optional output pin.
 * Assumes analog voltages arrive as digital codes asynchronous to clk
 * and that software sets the power mode through the register slave.
 */
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control
	import comparator_pkg::*;
#(
	parameter int ANALOG_WIDTH = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_error,
	input wire logic [ANALOG_WIDTH-1:0] positiveInput,
	input wire logic [ANALOG_WIDTH-1:0] negativeInput,
	input wire logic [ANALOG_WIDTH-1:0] bandgapReference,
	input wire logic debugActive,
	output logic comparatorOutputPin,
	output logic comparatorOutputPinOe,
	output logic eventIrq,
	output logic irq
);
	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	// Refuse analog widths the compare path was not sized for
	if (ANALOG_WIDTH < 1 || ANALOG_WIDTH > 16) begin : widthCheck
		$error("ANALOG_WIDTH out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic comparatorEnable;
	logic referenceSelect;
	logic compareEventFlag;
	logic eventInterruptEnable;
	logic outputPinEnable;
	logic [1:0] eventEdgeSelect;
	logic [2:0] powerMode;
	logic irqStatus;
	logic irqMask;
	logic answerPending;
	logic next_comparatorEnable;
	logic next_referenceSelect;
	logic next_compareEventFlag;
	logic next_eventInterruptEnable;
	logic next_outputPinEnable;
	logic [1:0] next_eventEdgeSelect;
	logic [2:0] next_powerMode;
	logic next_irqStatus;
	logic next_irqMask;
	logic next_answerPending;
	logic [31:0] next_readdata;
	logic next_error;
	logic next_pin;
	logic next_pinOe;
	logic next_eventIrq;
	logic next_irq;
	logic anyStop;
	logic comparing;
	logic [ANALOG_WIDTH-1:0] nonInverting;
	logic decision;
	logic request;
	logic writeTaken;
	logic byteZero;
	logic [7:0] statusControl;

	comparator_if link();

	// ------------------------------------------------------------
	// Analog path
	// ------------------------------------------------------------
	// Stop modes power the comparator down; wait and debug do not
	always_comb begin
		anyStop = powerMode[LIGHT_STOP_BIT] | powerMode[DEEP_STOP_BIT];
		comparing = comparatorEnable & ~anyStop;
		nonInverting = referenceSelect ? bandgapReference : positiveInput;
	end

	compare_model #(
		.WIDTH(ANALOG_WIDTH)
	) analogCore (
		.nonInverting(nonInverting),
		.inverting(negativeInput),
		.powered(comparing),
		.decision(decision)
	);

	// Feed the detector
	always_comb begin
		link.active = comparing;
		link.edgeSelect = eventEdgeSelect;
		link.rawCompare = decision;
	end

	compare_edge_detect edgeDetect (
		.clk(clk),
		.rst(rst),
		.port(link)
	);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// Readable image of the status/control register
	always_comb begin
		statusControl = STATUS_CONTROL_RESET;
		statusControl[ENABLE_BIT] = comparatorEnable;
		statusControl[REF_SELECT_BIT] = referenceSelect;
		statusControl[EVENT_FLAG_BIT] = compareEventFlag;
		statusControl[EVENT_IRQ_ENABLE_BIT] = eventInterruptEnable;
		statusControl[OUTPUT_STATUS_BIT] = link.syncedCompare;
		statusControl[PIN_ENABLE_BIT] = outputPinEnable;
		statusControl[EDGE_SELECT_LSB +: 2] = eventEdgeSelect;
	end

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	// A request is taken only while no answer is pending
	always_comb begin
		request = (avs_read | avs_write) & ~answerPending;
		writeTaken = avs_write & ~answerPending;
		byteZero = avs_byteenable[0];
		next_answerPending = request;
	end

	// ------------------------------------------------------------
	// Control bits
	// ------------------------------------------------------------
	// Byte lane 0 of a taken write loads the control fields
	always_comb begin
		next_comparatorEnable = comparatorEnable;
		next_referenceSelect = referenceSelect;
		next_eventInterruptEnable = eventInterruptEnable;
		next_outputPinEnable = outputPinEnable;
		next_eventEdgeSelect = eventEdgeSelect;
		next_powerMode = powerMode;
		next_irqMask = irqMask;
		if (writeTaken && byteZero) begin
			unique case (avs_address)
				STATUS_CONTROL_OFFSET: begin
					next_comparatorEnable = avs_writedata[ENABLE_BIT];
					next_referenceSelect = avs_writedata[REF_SELECT_BIT];
					next_eventInterruptEnable = avs_writedata[EVENT_IRQ_ENABLE_BIT];
					next_outputPinEnable = avs_writedata[PIN_ENABLE_BIT];
					next_eventEdgeSelect = avs_writedata[EDGE_SELECT_LSB +: 2];
				end
				IRQ_MASK_OFFSET: begin
					next_irqMask = avs_writedata[IRQ_EVENT_BIT];
				end
				POWER_MODE_OFFSET: begin
					next_powerMode = avs_writedata[DEEP_STOP_BIT:WAIT_MODE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	// Writing one clears a flag; an event in the same cycle still sets it
	always_comb begin
		next_compareEventFlag = compareEventFlag;
		next_irqStatus = irqStatus;
		if (writeTaken && byteZero) begin
			if (avs_address == STATUS_CONTROL_OFFSET && avs_writedata[EVENT_FLAG_BIT]) begin
				next_compareEventFlag = 1'b0;
			end
			if (avs_address == IRQ_STATUS_OFFSET && avs_writedata[IRQ_EVENT_BIT]) begin
				next_irqStatus = 1'b0;
			end
		end
		if (link.eventPulse) begin
			next_compareEventFlag = 1'b1;
			next_irqStatus = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Read answer
	// ------------------------------------------------------------
	// Read data is captured on the taking edge; unmapped addresses answer with error
	always_comb begin
		next_readdata = 32'h0;
		next_error = 1'b0;
		if (request) begin
			unique case (avs_address)
				STATUS_CONTROL_OFFSET: next_readdata = {24'h0, statusControl};
				IRQ_STATUS_OFFSET: next_readdata = {31'h0, irqStatus};
				IRQ_MASK_OFFSET: next_readdata = {31'h0, irqMask};
				POWER_MODE_OFFSET: next_readdata = {29'h0, powerMode};
				default: next_error = 1'b1;
			endcase
			if (!avs_read) begin
				next_readdata = 32'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output values
	// ------------------------------------------------------------
	// Pin levels follow the registered state; request levels use the next flag values
	always_comb begin
		next_pin = outputPinEnable & link.syncedCompare;
		next_pinOe = outputPinEnable;
		next_eventIrq = eventInterruptEnable & next_compareEventFlag;
		next_irq = irqMask & next_irqStatus;
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Light stop leaves every register untouched; only rst restores them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			comparatorEnable <= 1'b0;
			referenceSelect <= 1'b0;
			eventInterruptEnable <= 1'b0;
			outputPinEnable <= 1'b0;
			eventEdgeSelect <= EDGE_FALL_A;
			powerMode <= 3'h0;
			irqMask <= 1'b0;
		end else begin
			comparatorEnable <= next_comparatorEnable;
			referenceSelect <= next_referenceSelect;
			eventInterruptEnable <= next_eventInterruptEnable;
			outputPinEnable <= next_outputPinEnable;
			eventEdgeSelect <= next_eventEdgeSelect;
			powerMode <= next_powerMode;
			irqMask <= next_irqMask;
		end
	end

	// ------------------------------------------------------------
	// Flag registers
	// ------------------------------------------------------------
	// Sticky flags, cleared by reset or by a write of one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compareEventFlag <= 1'b0;
			irqStatus <= 1'b0;
		end else begin
			compareEventFlag <= next_compareEventFlag;
			irqStatus <= next_irqStatus;
		end
	end

	// ------------------------------------------------------------
	// Bus answer registers
	// ------------------------------------------------------------
	// Waitrequest drops for exactly one cycle after each taken request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			answerPending <= 1'b0;
			avs_readdata <= 32'h0;
			avs_waitrequest <= 1'b1;
			avs_response_error <= 1'b0;
		end else begin
			answerPending <= next_answerPending;
			avs_readdata <= next_readdata;
			avs_waitrequest <= ~next_answerPending;
			avs_response_error <= next_error;
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Every top output comes straight from a register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			comparatorOutputPin <= 1'b0;
			comparatorOutputPinOe <= 1'b0;
			eventIrq <= 1'b0;
			irq <= 1'b0;
		end else begin
			comparatorOutputPin <= next_pin;
			comparatorOutputPinOe <= next_pinOe;
			eventIrq <= next_eventIrq;
			irq <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Debug input
	// ------------------------------------------------------------
	// Debug level passes two flops and is deliberately given no effect
	logic debugFirst;
	logic debugSeen;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			debugFirst <= 1'b0;
			debugSeen <= 1'b0;
		end else begin
			debugFirst <= debugActive;
			debugSeen <= debugFirst;
		end
	end
endmodule
`default_nettype wire

// file: hw/comparator_pkg.sv
/*
 * Constants shared by the comparator control block: register map, bit
 * positions, reset value and event edge encodings.
 * Assumes a 32-bit Avalon-MM slave with word addressing on byte offsets.
 */
package comparator_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
	localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
	localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
	localparam logic [3:0] POWER_MODE_OFFSET = 4'hc;

	// ------------------------------------------------------------
	// Status/control bit positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT = 7;
	localparam int REF_SELECT_BIT = 6;
	localparam int EVENT_FLAG_BIT = 5;
	localparam int EVENT_IRQ_ENABLE_BIT = 4;
	localparam int OUTPUT_STATUS_BIT = 3;
	localparam int PIN_ENABLE_BIT = 2;
	localparam int EDGE_SELECT_LSB = 0;
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;

	// Power mode register bits
	localparam int WAIT_MODE_BIT = 0;
	localparam int LIGHT_STOP_BIT = 1;
	localparam int DEEP_STOP_BIT = 2;

	// Interrupt status bits
	localparam int IRQ_EVENT_BIT = 0;

	// Event edge encodings
	localparam logic [1:0] EDGE_FALL_A = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL_B = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// file: hw/comparator_if.sv
/*
 * Interface between the control top and its edge detector.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface comparator_if;
	logic active;
	logic [1:0] edgeSelect;
	logic rawCompare;
	logic syncedCompare;
	logic eventPulse;

	modport control(output active, output edgeSelect, output rawCompare, input syncedCompare, input eventPulse);
	modport detector(input active, input edgeSelect, input rawCompare, output syncedCompare, output eventPulse);
endinterface
`default_nettype wire

// file: hw/compare_edge_detect.sv
/*
 * Synchronises the analog comparator decision and finds the chosen edge.
 * Assumes the raw decision is asynchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module compare_edge_detect
	import comparator_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	comparator_if.detector port
);
	logic syncFirst;
	logic syncSecond;
	logic previous;
	logic next_syncFirst;
	logic next_syncSecond;
	logic next_previous;
	logic risen;
	logic fallen;

	// Next values; history sample forced low while inactive
	always_comb begin
		next_syncFirst = port.rawCompare;
		next_syncSecond = syncFirst;
		next_previous = port.active ? syncSecond : 1'b0;
	end

	// Two-stage synchroniser and sample history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncFirst <= 1'b0;
			syncSecond <= 1'b0;
			previous <= 1'b0;
		end else begin
			syncFirst <= next_syncFirst;
			syncSecond <= next_syncSecond;
			previous <= next_previous;
		end
	end

	// Edges compare successive samples, never reported while off
	always_comb begin
		risen = port.active & syncSecond & ~previous;
		fallen = port.active & ~syncSecond & previous;
		port.syncedCompare = port.active & syncSecond;
		unique case (port.edgeSelect)
			EDGE_FALL_A: port.eventPulse = fallen;
			EDGE_RISE: port.eventPulse = risen;
			EDGE_FALL_B: port.eventPulse = fallen;
			EDGE_BOTH: port.eventPulse = risen | fallen;
		endcase
	end
endmodule
`default_nettype wire

// file: hw/compare_model.sv
/*
 * Comparator decision from the digitised analog inputs.
 * Assumes inputs are codes of the voltages, compared unsigned.
 */
`timescale 1ns/1ns
`default_nettype none
module compare_model #(
	parameter int WIDTH = 10
) (
	input wire logic [WIDTH-1:0] nonInverting,
	input wire logic [WIDTH-1:0] inverting,
	input wire logic powered,
	output logic decision
);
	// High when powered and non-inverting exceeds inverting
	always_comb begin
		decision = powered & (nonInverting > inverting);
	end
endmodule
`default_nettype wire

// file: testbench/analog_comparator_control_monitor.sv
/* Checker of the comparator block, bound to the top module.
   Assumes it sees the top ports only, one clock, async reset. */
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control_monitor
	import comparator_pkg::*;
#(
	parameter int ANALOG_WIDTH = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic avs_response_error,
	input wire logic [ANALOG_WIDTH-1:0] positiveInput,
	input wire logic [ANALOG_WIDTH-1:0] negativeInput,
	input wire logic [ANALOG_WIDTH-1:0] bandgapReference,
	input wire logic comparatorOutputPin,
	input wire logic comparatorOutputPinOe,
	input wire logic eventIrq,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] ctrl, mask, pwr;
	logic stop, want, live, rdAns;

	// Shadow of the control bits as accepted writes leave them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= 8'h00;
			mask <= 8'h00;
			pwr <= 8'h00;
		end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
			if (avs_address == STATUS_CONTROL_OFFSET) ctrl <= avs_writedata[7:0] & 8'hd7;
			if (avs_address == IRQ_MASK_OFFSET) mask <= avs_writedata[7:0];
			if (avs_address == POWER_MODE_OFFSET) pwr <= avs_writedata[7:0];
		end
	end

	// Expected decision and qualifiers
	assign stop = pwr[LIGHT_STOP_BIT] | pwr[DEEP_STOP_BIT];
	assign want = (ctrl[REF_SELECT_BIT] ? bandgapReference : positiveInput) > negativeInput;
	assign live = ctrl[ENABLE_BIT] & ctrl[PIN_ENABLE_BIT] & !stop;
	assign rdAns = avs_read & !avs_waitrequest;

	// ----------------
	// Assertions
	// ----------------
	property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("request not answered next cycle");
	property p_once; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_once: assert property (p_once) else $error("answer held too long");
	property p_error; rdAns && avs_address[1:0] != 2'h0 |-> avs_response_error && avs_readdata == 32'h0; endproperty
	a_error: assert property (p_error) else $error("unmapped read not refused");
	property p_status; rdAns && !ctrl[ENABLE_BIT] && !$past(ctrl[ENABLE_BIT], 3) |-> !avs_readdata[3]; endproperty
	a_status: assert property (p_status) else $error("output status set while off");
	property p_pin; (live && $stable(want)) [*5] |-> comparatorOutputPin == want; endproperty
	a_pin: assert property (p_pin) else $error("pin differs from comparison");
	property p_pin_off; !ctrl[PIN_ENABLE_BIT] [*2] |-> !comparatorOutputPin; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");
	property p_oe; $stable(ctrl) |-> comparatorOutputPinOe == ctrl[PIN_ENABLE_BIT]; endproperty
	a_oe: assert property (p_oe) else $error("pin enable mismatch");
	property p_ie; !ctrl[EVENT_IRQ_ENABLE_BIT] [*2] |-> !eventIrq; endproperty
	a_ie: assert property (p_ie) else $error("event request while disabled");
	property p_mask; !mask[IRQ_EVENT_BIT] [*2] |-> !irq; endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt raised");
	property p_stop; (stop && $stable(ctrl)) [*5] |-> !$rose(eventIrq); endproperty
	a_stop: assert property (p_stop) else $error("event seen in stop");

	c_err: cover property (rdAns && avs_response_error);
	c_event: cover property ($rose(eventIrq));
	c_irq: cover property ($rose(irq));
endmodule

bind analog_comparator_control analog_comparator_control_monitor #(.ANALOG_WIDTH(ANALOG_WIDTH)) u_mon (.clk, .rst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.avs_response_error, .positiveInput, .negativeInput, .bandgapReference, .comparatorOutputPin,
	.comparatorOutputPinOe, .eventIrq, .irq);
`default_nettype wire

// file: testbench/analog_source.sv
/* Analog voltages at the comparator inputs, as unsigned codes.
   Assumes the bench picks the level of each pin. */
`timescale 1ns/1ns
`default_nettype none
module analog_source #(
	parameter int WIDTH = 10
) (
	input wire logic posHigh,
	input wire logic negHigh,
	output logic [WIDTH-1:0] positiveInput,
	output logic [WIDTH-1:0] negativeInput,
	output logic [WIDTH-1:0] bandgapReference
);
	// Levels chosen so the reference lies between the two negative levels
	assign positiveInput = posHigh ? WIDTH'(10'h258) : WIDTH'(10'h0c8);
	assign negativeInput = negHigh ? WIDTH'(10'h2bc) : WIDTH'(10'h190);
	assign bandgapReference = WIDTH'(10'h1f4);
endmodule
`default_nettype wire

// file: testbench/analog_comparator_control_tb.sv
/* Self-checking bench of the comparator control block.
   Assumes the checker is bound to the top module. */
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control_tb;
	logic clk, avs_waitrequest, avs_response_error, comparatorOutputPin, comparatorOutputPinOe, eventIrq, irq, rdErr, f;
	logic rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, debugActive = 1'b0, posHigh = 1'b1, negHigh = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [9:0] positiveInput, negativeInput, bandgapReference;
	logic [7:0] q, ctl;
	int nErrors = 0, nTests = 0, cycles = 0;

	analog_source u_src (.posHigh, .negHigh, .positiveInput, .negativeInput, .bandgapReference);
	analog_comparator_control u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_error, .positiveInput, .negativeInput,
		.bandgapReference, .debugActive, .comparatorOutputPin, .comparatorOutputPinOe, .eventIrq, .irq);

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nErrors++;
			endOfTest();
		end
	end

	// Bus cycles and comparisons
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do @(posedge clk); while (avs_waitrequest);
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		avs_read <= 1'b1;
		avs_address <= a;
		do @(posedge clk); while (avs_waitrequest);
		q = avs_readdata[7:0];
		rdErr = avs_response_error;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
		nTests++;
		if (g !== x) begin
			nErrors++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic cr(input logic [3:0] a, input logic [7:0] x);
		rd(a);
		chk("register", x, q);
		chk("error", 8'(a[1:0] != 2'h0), 8'(rdErr));
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		cr(4'h0, 8'h00);
		cr(4'h4, 8'h00);
		cr(4'h8, 8'h00);
		cr(4'hc, 8'h00);
		wr(4'h0, 8'h84);
		wt(6);
		cr(4'h0, 8'h8c);
		chk("pin", 8'h01, 8'(comparatorOutputPin));
		chk("pin enable", 8'h01, 8'(comparatorOutputPinOe));
		negHigh <= 1'b1;
		wr(4'h0, 8'hc4);
		wt(6);
		cr(4'h0, 8'he4);
		chk("pin", 8'h00, 8'(comparatorOutputPin));
		wr(4'h0, 8'hc4);
		cr(4'h0, 8'he4);
		wr(4'h0, 8'he4);
		cr(4'h0, 8'hc4);
		posHigh <= 1'b0;
		negHigh <= 1'b0;
		wt(6);
		cr(4'h0, 8'hcc);
		wr(4'h0, 8'h84);
		wt(6);
		cr(4'h0, 8'ha4);
		$display("test comparison done");
		for (int m = 0; m < 4; m++) begin
			ctl = 8'h90 | 8'(m);
			wr(4'h0, ctl | 8'h20);
			posHigh <= 1'b1;
			wt(6);
			f = (m == 1 || m == 3);
			cr(4'h0, ctl | {2'h0, f, 5'h08});
			chk("event irq", 8'(f), 8'(eventIrq));
			wr(4'h0, ctl | 8'h20);
			posHigh <= 1'b0;
			wt(6);
			f = (m != 1);
			cr(4'h0, ctl | {2'h0, f, 5'h00});
			chk("event irq", 8'(f), 8'(eventIrq));
		end
		wr(4'h0, 8'ha3);
		posHigh <= 1'b1;
		wt(6);
		cr(4'h0, 8'hab);
		chk("event irq", 8'h00, 8'(eventIrq));
		cr(4'h4, 8'h01);
		chk("irq", 8'h00, 8'(irq));
		wr(4'h4, 8'h00);
		cr(4'h4, 8'h01);
		wr(4'h8, 8'h01);
		wt(2);
		chk("irq", 8'h01, 8'(irq));
		wr(4'h4, 8'h01);
		wt(2);
		chk("irq", 8'h00, 8'(irq));
		cr(4'h4, 8'h00);
		$display("test events done");
		wr(4'h0, 8'ha3);
		cr(4'h0, 8'h8b);
		wr(4'hc, 8'h01);
		debugActive <= 1'b1;
		posHigh <= 1'b0;
		wt(6);
		cr(4'h0, 8'ha3);
		debugActive <= 1'b0;
		for (int s = 2; s < 5; s += 2) begin
			wr(4'h0, 8'ha3);
			wr(4'hc, 8'(s));
			posHigh <= ~posHigh;
			wt(6);
			cr(4'h0, 8'h83);
		end
		wr(4'hc, 8'h00);
		wt(6);
		cr(4'h0, 8'h83);
		wr(4'h0, 8'h07);
		posHigh <= 1'b1;
		wt(6);
		cr(4'h0, 8'h07);
		chk("pin", 8'h00, 8'(comparatorOutputPin));
		avs_byteenable <= 4'h0;
		wr(4'h0, 8'h84);
		avs_byteenable <= 4'h1;
		wr(4'h2, 8'hff);
		cr(4'h0, 8'h07);
		cr(4'h2, 8'h00);
		$display("test modes done");
		rst <= 1'b1;
		wt(2);
		rst <= 1'b0;
		cr(4'h0, 8'h00);
		cr(4'h8, 8'h00);
		$display("test reset exit done");
		endOfTest();
	end
endmodule
`default_nettype wire
